// >>> lms_cfg.svh
// Constants of the listen mode sequencer: link addresses, field positions,
// reset values and the recommended preset words.
// Assumes inclusion by bare name from the device, host, checker and testbench files.
`ifndef LMS_CFG_SVH
`define LMS_CFG_SVH

// Device link register addresses
`define LMS_A_SEQ        4'h0
`define LMS_A_T1         4'h1
`define LMS_A_T2         4'h2
`define LMS_A_RXTO       4'h3
`define LMS_A_MAP        4'h4
`define LMS_A_CMD        4'h5

// Sequencer word fields, then the route bit of the pin map word
`define LMS_F_SLEEP      0
`define LMS_F_START_LO   1
`define LMS_F_START_HI   2
`define LMS_F_LOWP       3
`define LMS_F_IDLE       4
`define LMS_F_RECV_LO    5
`define LMS_F_RECV_HI    7
`define LMS_F_RXTO_LO    8
`define LMS_F_RXTO_HI    9
`define LMS_F_ROUTE      10

// Command word fields
`define LMS_F_CMD_START  0
`define LMS_F_CMD_STOP   1

// Field codes
`define LMS_START_LOWP   2'h0
`define LMS_RECV_PAYLOAD 3'h4
`define LMS_RECV_SYNC    3'h5
`define LMS_RECV_PRE     3'h6
`define LMS_RXTO_LOWP    2'h2

// Reset values
`define LMS_SEQ_RST      10'h000
`define LMS_MAP_RST      11'h000
`define LMS_TMR_RST      16'h0000

// Preset words the host sends
`define LMS_SEQ_PRE      16'h02D9
`define LMS_SEQ_SYNC     16'h02B9
`define LMS_MAP_PRESET   16'h0731

// Host software register addresses
`define LMS_H_CTRL       4'h0
`define LMS_H_T1         4'h1
`define LMS_H_T2         4'h2
`define LMS_H_RXTO       4'h3
`define LMS_H_STATUS     4'h4
`define LMS_H_MASK       4'h5

// Host control and status bits
`define LMS_C_GO_PRE     0
`define LMS_C_GO_SYNC    1
`define LMS_C_STOP       2
`define LMS_S_CRC        0
`define LMS_S_PRE        1
`define LMS_S_SYNC       2

// Host send sequence
`define LMS_STEP_LAST    3'h5

`endif

// >>> lms_pkg.sv
// Types shared by both ends of the listen mode sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lms_pkg;
    typedef enum logic [3:0] {
        LMS_OFF  = 4'h1,
        LMS_IDLE = 4'h2,
        LMS_RX   = 4'h4,
        LMS_HOLD = 4'h8
    } lms_dev_state_e;

    typedef enum logic [1:0] {
        LMS_H_WAIT = 2'h1,
        LMS_H_SEND = 2'h2
    } lms_host_state_e;

    typedef logic [4:0] lms_dio_t;
endpackage
`default_nettype wire

// >>> lms_link_if.sv
// Link between the host controller and the listen sequencer device.
// Assumes both ends share one clock; the host synchronises the pins.
`timescale 1ns/1ps
`default_nettype none
interface lms_link_if;
    logic              wr;
    logic [3:0]        addr;
    logic [15:0]       wdata;
    lms_pkg::lms_dio_t dio;

    modport dev  (input wr, input addr, input wdata, output dio);
    modport host (output wr, output addr, output wdata, input dio);
endinterface
`default_nettype wire

// >>> lms_dev.sv
// Listen mode sequencer device: config written over the link, a timer
// driven idle/receive cycle, and event routing onto five pins.
// Assumes radio event inputs are single-clock logic on CLK.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "lms_cfg.svh"
module lms_dev #(
    parameter int TW = 16
) (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RST,
    // Host link
    lms_link_if.dev   LINK,
    // Radio events
    input  wire logic PREAMBLE_FOUND,
    input  wire logic SYNC_MATCH,
    input  wire logic PAYLOAD_COMPLETE,
    input  wire logic CRC_PASS,
    input  wire logic FIFO_THRESHOLD,
    input  wire logic FIFO_DRAINED,
    input  wire logic RSSI_IRQ,
    // Radio power state
    output logic      RX_ON,
    output logic      IDLE_ON,
    output logic      SLEEP_ON,
    output logic      SEQ_ON
);
    generate
        if (TW < 2 || TW > 16) begin : g_bad_tw
            $error("lms_dev: TW must be 2 to 16");
        end
    endgenerate

    lms_pkg::lms_dev_state_e st_q;
    lms_pkg::lms_dev_state_e st_d;
    logic [9:0]    seq_q;
    logic [9:0]    seq_d;
    logic [10:0]   map_q;
    logic [10:0]   map_d;
    logic [TW-1:0] t1_q;
    logic [TW-1:0] t1_d;
    logic [TW-1:0] t2_q;
    logic [TW-1:0] t2_d;
    logic [TW-1:0] rxto_q;
    logic [TW-1:0] rxto_d;
    logic [TW:0]   cnt_q;
    logic [TW:0]   cnt_d;
    logic [TW-1:0] rxc_q;
    logic [TW-1:0] rxc_d;
    logic          done_q;
    logic          done_d;
    logic          pre_q;
    logic          pre_d;
    logic [4:0]    dio_q;
    logic [4:0]    dio_d;
    logic          start_p;
    logic          stop_p;
    logic [TW:0]   period;
    logic [TW:0]   cnt_nx;
    logic          wrap;
    logic          stop_ev;
    logic          rxto_armed;
    logic [7:0]    ev;

    // Config writes
    always_comb begin
        seq_d  = seq_q;
        map_d  = map_q;
        t1_d   = t1_q;
        t2_d   = t2_q;
        rxto_d = rxto_q;
        if (LINK.wr) begin
            case (LINK.addr)
                `LMS_A_SEQ:  seq_d  = LINK.wdata[9:0];
                `LMS_A_MAP:  map_d  = LINK.wdata[10:0];
                `LMS_A_T1:   t1_d   = LINK.wdata[TW-1:0];
                `LMS_A_T2:   t2_d   = LINK.wdata[TW-1:0];
                `LMS_A_RXTO: rxto_d = LINK.wdata[TW-1:0];
                default: ;
            endcase
        end
    end

    assign start_p = LINK.wr && (LINK.addr == `LMS_A_CMD)
                     && LINK.wdata[`LMS_F_CMD_START];
    assign stop_p  = LINK.wr && (LINK.addr == `LMS_A_CMD)
                     && LINK.wdata[`LMS_F_CMD_STOP];

    assign period = {1'b0, t1_q} + {1'b0, t2_q};
    assign cnt_nx = cnt_q + {{TW{1'b0}}, 1'b1};
    assign wrap   = (cnt_nx >= period);

    // Stop condition chosen by the receive exit code
    always_comb begin
        case (seq_q[`LMS_F_RECV_HI:`LMS_F_RECV_LO])
            `LMS_RECV_PRE:     stop_ev = PREAMBLE_FOUND;
            `LMS_RECV_SYNC:    stop_ev = SYNC_MATCH;
            `LMS_RECV_PAYLOAD: stop_ev = PAYLOAD_COMPLETE;
            default:           stop_ev = 1'b0;
        endcase
    end
    assign rxto_armed =
        (seq_q[`LMS_F_RECV_HI:`LMS_F_RECV_LO] == `LMS_RECV_SYNC);

    // Sequencer
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        rxc_d  = rxc_q;
        done_d = done_q;
        pre_d  = pre_q;
        // Cycle timer runs only while the sequencer is on
        if (st_q == lms_pkg::LMS_IDLE || st_q == lms_pkg::LMS_RX) begin
            cnt_d = wrap ? '0 : cnt_nx;
            if (wrap) begin
                done_d = 1'b0;
            end
        end
        case (st_q)
            lms_pkg::LMS_OFF: ;
            lms_pkg::LMS_IDLE: begin
                if (!done_q && (cnt_nx >= {1'b0, t1_q}) && !wrap) begin
                    if (seq_q[`LMS_F_IDLE]) begin
                        st_d  = lms_pkg::LMS_RX;
                        rxc_d = '0;
                        pre_d = 1'b0;
                    end else begin
                        done_d = 1'b1;
                    end
                end
            end
            lms_pkg::LMS_RX: begin
                rxc_d = rxc_q + {{(TW-1){1'b0}}, 1'b1};
                if (PREAMBLE_FOUND) begin
                    pre_d = 1'b1;
                end
                if (stop_ev) begin
                    st_d = lms_pkg::LMS_HOLD;
                end else if (wrap) begin
                    st_d = lms_pkg::LMS_IDLE;
                end else if (rxto_armed && !pre_q && !PREAMBLE_FOUND
                             && (rxc_d >= rxto_q)) begin
                    done_d = 1'b1;
                    if (seq_q[`LMS_F_RXTO_HI:`LMS_F_RXTO_LO]
                        == `LMS_RXTO_LOWP) begin
                        st_d = lms_pkg::LMS_IDLE;
                    end else begin
                        st_d = lms_pkg::LMS_OFF;
                    end
                end
            end
            lms_pkg::LMS_HOLD: ;
            default: st_d = lms_pkg::LMS_OFF;
        endcase
        // Commands override timers in every state
        if (stop_p) begin
            st_d = lms_pkg::LMS_OFF;
        end else if (start_p) begin
            cnt_d  = '0;
            rxc_d  = '0;
            done_d = 1'b0;
            pre_d  = 1'b0;
            if (seq_q[`LMS_F_START_HI:`LMS_F_START_LO] == `LMS_START_LOWP)
            begin
                st_d = seq_q[`LMS_F_LOWP] ? lms_pkg::LMS_IDLE
                                           : lms_pkg::LMS_OFF;
            end else begin
                st_d = lms_pkg::LMS_RX;
            end
        end
    end

    // Event vector for pin routing
    assign ev = {RX_ON,
                 st_q == lms_pkg::LMS_HOLD,
                 map_q[`LMS_F_ROUTE] ? PREAMBLE_FOUND : RSSI_IRQ,
                 SYNC_MATCH,
                 FIFO_DRAINED,
                 FIFO_THRESHOLD,
                 CRC_PASS,
                 PAYLOAD_COMPLETE};

    // Event index per pin, three bits per code, pin 4 on top
    localparam logic [59:0] pin_ev_tab = {
        3'h5, 3'h2, 3'h7, 3'h6,
        3'h1, 3'h6, 3'h2, 3'h3,
        3'h4, 3'h0, 3'h7, 3'h3,
        3'h1, 3'h0, 3'h3, 3'h2,
        3'h5, 3'h2, 3'h1, 3'h0
    };

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_dio
            assign dio_d[g] = ev[pin_ev_tab[12*g + 3*map_q[2*g+1:2*g] +: 3]];
        end
    endgenerate

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q   <= lms_pkg::LMS_OFF;
            seq_q  <= `LMS_SEQ_RST;
            map_q  <= `LMS_MAP_RST;
            t1_q   <= '0;
            t2_q   <= '0;
            rxto_q <= '0;
            cnt_q  <= '0;
            rxc_q  <= '0;
            done_q <= 1'b0;
            pre_q  <= 1'b0;
            dio_q  <= 5'h00;
        end else begin
            st_q   <= st_d;
            seq_q  <= seq_d;
            map_q  <= map_d;
            t1_q   <= t1_d;
            t2_q   <= t2_d;
            rxto_q <= rxto_d;
            cnt_q  <= cnt_d;
            rxc_q  <= rxc_d;
            done_q <= done_d;
            pre_q  <= pre_d;
            dio_q  <= dio_d;
        end
    end

    assign LINK.dio = dio_q;
    assign RX_ON    = (st_q == lms_pkg::LMS_RX) || (st_q == lms_pkg::LMS_HOLD);
    assign IDLE_ON  = (st_q == lms_pkg::LMS_IDLE);
    assign SLEEP_ON = IDLE_ON && seq_q[`LMS_F_SLEEP];
    assign SEQ_ON   = IDLE_ON || (st_q == lms_pkg::LMS_RX);
endmodule
`default_nettype wire

// >>> lms_host.sv
// Host end of the listen sequencer: software registers, a preset sender
// that programs the device, and a status/mask interrupt from event pins.
// Assumes the device pins may change on any edge; they are synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "lms_cfg.svh"
module lms_host (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Software port
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    output logic             IRQ,
    // Device link
    lms_link_if.host         LINK
);
    lms_pkg::lms_host_state_e st_q;
    lms_pkg::lms_host_state_e st_d;
    logic [2:0]  step_q;
    logic [2:0]  step_d;
    logic        sync_q;
    logic        sync_d;
    logic        stop_q;
    logic        stop_d;
    logic [15:0] t1_q;
    logic [15:0] t1_d;
    logic [15:0] t2_q;
    logic [15:0] t2_d;
    logic [15:0] rxto_q;
    logic [15:0] rxto_d;
    logic [2:0]  stat_q;
    logic [2:0]  stat_d;
    logic [2:0]  mask_q;
    logic [2:0]  mask_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        lwr_q;
    logic        lwr_d;
    logic [3:0]  laddr_q;
    logic [3:0]  laddr_d;
    logic [15:0] ldata_q;
    logic [15:0] ldata_d;
    logic [4:0]  s1_q;
    logic [4:0]  s2_q;
    logic [4:0]  s3_q;
    logic [2:0]  ev;
    logic        ctrl_wr;

    // Rising edges of the synchronised event pins
    assign ev = {s2_q[2] & ~s3_q[2], s2_q[4] & ~s3_q[4], s2_q[0] & ~s3_q[0]};
    assign ctrl_wr = WR && (ADDR == `LMS_H_CTRL);

    always_comb begin
        st_d    = st_q;
        step_d  = step_q;
        sync_d  = sync_q;
        stop_d  = stop_q;
        t1_d    = t1_q;
        t2_d    = t2_q;
        rxto_d  = rxto_q;
        mask_d  = mask_q;
        lwr_d   = 1'b0;
        laddr_d = laddr_q;
        ldata_d = ldata_q;
        rdata_d = 16'h0000;
        // Set wins over the read clear
        stat_d  = ((RD && ADDR == `LMS_H_STATUS) ? 3'h0 : stat_q) | ev;
        if (WR) begin
            case (ADDR)
                `LMS_H_T1:   t1_d   = WDATA;
                `LMS_H_T2:   t2_d   = WDATA;
                `LMS_H_RXTO: rxto_d = WDATA;
                `LMS_H_MASK: mask_d = WDATA[2:0];
                default: ;
            endcase
        end
        if (RD) begin
            case (ADDR)
                `LMS_H_CTRL:
                    rdata_d = {15'h0000, st_q == lms_pkg::LMS_H_SEND};
                `LMS_H_T1:     rdata_d = t1_q;
                `LMS_H_T2:     rdata_d = t2_q;
                `LMS_H_RXTO:   rdata_d = rxto_q;
                `LMS_H_STATUS: rdata_d = {13'h0000, stat_q};
                `LMS_H_MASK:   rdata_d = {13'h0000, mask_q};
                default:       rdata_d = 16'h0000;
            endcase
        end
        case (st_q)
            lms_pkg::LMS_H_WAIT: begin
                // Orders while busy are dropped
                if (ctrl_wr && WDATA[`LMS_C_STOP]) begin
                    st_d   = lms_pkg::LMS_H_SEND;
                    step_d = `LMS_STEP_LAST;
                    stop_d = 1'b1;
                end else if (ctrl_wr && (WDATA[`LMS_C_GO_PRE]
                                         || WDATA[`LMS_C_GO_SYNC])) begin
                    st_d   = lms_pkg::LMS_H_SEND;
                    step_d = 3'h0;
                    stop_d = 1'b0;
                    sync_d = WDATA[`LMS_C_GO_SYNC];
                end
            end
            lms_pkg::LMS_H_SEND: begin
                lwr_d = 1'b1;
                case (step_q)
                    3'h0: begin
                        laddr_d = `LMS_A_SEQ;
                        ldata_d = sync_q ? `LMS_SEQ_SYNC : `LMS_SEQ_PRE;
                    end
                    3'h1: begin
                        laddr_d = `LMS_A_T1;
                        ldata_d = t1_q;
                    end
                    3'h2: begin
                        laddr_d = `LMS_A_T2;
                        ldata_d = t2_q;
                    end
                    3'h3: begin
                        laddr_d = `LMS_A_RXTO;
                        ldata_d = rxto_q;
                    end
                    3'h4: begin
                        laddr_d = `LMS_A_MAP;
                        ldata_d = `LMS_MAP_PRESET;
                    end
                    default: begin
                        laddr_d = `LMS_A_CMD;
                        ldata_d = stop_q ? 16'h0002 : 16'h0001;
                    end
                endcase
                if (step_q == `LMS_STEP_LAST) begin
                    st_d = lms_pkg::LMS_H_WAIT;
                end else begin
                    step_d = step_q + 3'h1;
                end
            end
            default: st_d = lms_pkg::LMS_H_WAIT;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q    <= lms_pkg::LMS_H_WAIT;
            step_q  <= 3'h0;
            sync_q  <= 1'b0;
            stop_q  <= 1'b0;
            t1_q    <= `LMS_TMR_RST;
            t2_q    <= `LMS_TMR_RST;
            rxto_q  <= `LMS_TMR_RST;
            stat_q  <= 3'h0;
            mask_q  <= 3'h0;
            rdata_q <= 16'h0000;
            lwr_q   <= 1'b0;
            laddr_q <= 4'h0;
            ldata_q <= 16'h0000;
            s1_q    <= 5'h00;
            s2_q    <= 5'h00;
            s3_q    <= 5'h00;
        end else begin
            st_q    <= st_d;
            step_q  <= step_d;
            sync_q  <= sync_d;
            stop_q  <= stop_d;
            t1_q    <= t1_d;
            t2_q    <= t2_d;
            rxto_q  <= rxto_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            rdata_q <= rdata_d;
            lwr_q   <= lwr_d;
            laddr_q <= laddr_d;
            ldata_q <= ldata_d;
            s1_q    <= LINK.dio;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
        end
    end

    assign RDATA      = rdata_q;
    assign IRQ        = |(stat_q & mask_q);
    assign LINK.wr    = lwr_q;
    assign LINK.addr  = laddr_q;
    assign LINK.wdata = ldata_q;
endmodule
`default_nettype wire

// >>> lms_link_properties.sv
// Concurrent checks on the words the host sends across the link.
// Assumes one clock and the async high reset shared by both ends.
`timescale 1ns/1ps
`default_nettype none
`include "lms_cfg.svh"
module lms_link_properties (
    // Clock and reset
    input wire logic              CLK,
    input wire logic              RST,
    // Link signals
    input wire logic              wr,
    input wire logic [3:0]        addr,
    input wire logic [15:0]       wdata,
    input wire lms_pkg::lms_dio_t dio
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    wire seq_w = wr && (addr == `LMS_A_SEQ);
    wire map_w = wr && (addr == `LMS_A_MAP);
    wire cmd_w = wr && (addr == `LMS_A_CMD);

    a_send_order: assert property (seq_w |=> (wr && addr == `LMS_A_T1)
        ##1 (wr && addr == `LMS_A_T2) ##1 (wr && addr == `LMS_A_RXTO)
        ##1 map_w ##1 (cmd_w && wdata[`LMS_F_CMD_START]))
        else $error("link words out of order");
    a_low_power_sel: assert property (seq_w |-> wdata[0] && wdata[3]
        && wdata[2:1] == `LMS_START_LOWP)
        else $error("sleep, start or low power select wrong");
    a_idle_recv_sel: assert property (seq_w |-> wdata[4]
        && (wdata[7:5] == `LMS_RECV_PRE || wdata[7:5] == `LMS_RECV_SYNC))
        else $error("idle or receive exit select wrong");
    a_sync_rxto_sel: assert property (
        seq_w && wdata[7:5] == `LMS_RECV_SYNC |-> wdata[9:8] == `LMS_RXTO_LOWP)
        else $error("timeout exit select wrong in sync mode");
    a_map_preset: assert property (map_w |-> wdata == `LMS_MAP_PRESET)
        else $error("pin map word wrong");
    a_route_bit: assert property (map_w |-> wdata[`LMS_F_ROUTE])
        else $error("preamble route bit clear");
    a_cmd_word: assert property (
        cmd_w |-> (wdata == 16'h0001 || wdata == 16'h0002))
        else $error("command word not start or stop");
    a_cmd_single: assert property (cmd_w |=> !wr)
        else $error("command word not a single pulse");

    cover property (seq_w && wdata == `LMS_SEQ_PRE);
    cover property (seq_w && wdata == `LMS_SEQ_SYNC);
    cover property (cmd_w && wdata[`LMS_F_CMD_STOP]);
    cover property ($rose(dio[4]));
endmodule
`default_nettype wire

// >>> tb_top.sv
// Testbench joining host and device ends over the link interface.
// Assumes the device runs from link timer words counted in CLK cycles.
`timescale 1ns/1ps
`default_nettype none
`include "lms_cfg.svh"
module tb_top;
    logic        CLK, RST, wr, rd, pre, syn, crc, rssi, pay, fthr, fdr;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata;
    logic        irq, rx_on, idle_on, sleep_on, seq_on;
    int          failures, n_compared;

    lms_link_if lnk ();
    lms_host i_lms_host (.CLK(CLK), .RST(RST), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .LINK(lnk));
    lms_dev #(.TW(16)) i_lms_dev (.CLK(CLK), .RST(RST), .LINK(lnk),
        .PREAMBLE_FOUND(pre), .SYNC_MATCH(syn), .PAYLOAD_COMPLETE(pay),
        .CRC_PASS(crc), .FIFO_THRESHOLD(fthr), .FIFO_DRAINED(fdr),
        .RSSI_IRQ(rssi), .RX_ON(rx_on), .IDLE_ON(idle_on),
        .SLEEP_ON(sleep_on), .SEQ_ON(seq_on));
    lms_link_properties i_lms_link_properties (.CLK(CLK), .RST(RST),
        .wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata), .dio(lnk.dio));

    task automatic close_out();
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return rx_on;
            1: return idle_on;
            default: return irq;
        endcase
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    // Bounded: a hang here ends the run as a failure
    task automatic wait_for(input int w, input logic v);
        int k;
        k = 0;
        while (sig(w) !== v && k < 300) begin
            tick(1);
            k++;
        end
        if (k == 300) begin
            failures++;
            $display("[ERR] %0t wait expired", $time);
            close_out();
        end
    endtask
    // Capped at 60 so a held state shows as exactly 60
    task automatic run_len(input int w, output int n);
        n = 0;
        while (sig(w) === 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge CLK);
        wr <= 1'b0;
        #1;
    endtask
    task automatic expect_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge CLK);
        addr <= a;
        rd <= 1'b1;
        @(posedge CLK);
        rd <= 1'b0;
        #1;
        check(rdata, e);
    endtask
    task automatic pulse(input int e);
        @(posedge CLK);
        case (e)
            0: pre <= 1'b1;
            1: syn <= 1'b1;
            2: crc <= 1'b1;
            default: rssi <= 1'b1;
        endcase
        @(posedge CLK);
        {pre, syn, crc, rssi} <= 4'h0;
        #1;
    endtask
    task automatic start(input logic [15:0] go, input logic [15:0] t2,
                         input logic [15:0] rxto);
        wreg(`LMS_H_T1, 16'h0008);
        wreg(`LMS_H_T2, t2);
        wreg(`LMS_H_RXTO, rxto);
        wreg(`LMS_H_CTRL, go);
        expect_reg(`LMS_H_CTRL, 16'h0001);
        wait_for(1, 1'b1);
    endtask
    task automatic stop();
        wreg(`LMS_H_CTRL, 16'h0001 << `LMS_C_STOP);
        tick(3);
        check({15'h0, rx_on}, 16'h0000);
    endtask

    task automatic t_reset();
        check({15'h0, rx_on}, 16'h0000);
        expect_reg(`LMS_H_STATUS, 16'h0000);
        expect_reg(`LMS_H_MASK, 16'h0000);
        wreg(4'hF, 16'hFFFF);
        expect_reg(4'hF, 16'h0000);
    endtask
    task automatic t_no_signal();
        int n;
        start(16'h0001 << `LMS_C_GO_PRE, 16'h0006, 16'h0003);
        wait_for(0, 1'b1);
        run_len(0, n);
        check(16'(n), 16'h0006);
        check({15'h0, sleep_on}, 16'h0001);
        run_len(1, n);
        check(16'(n), 16'h0008);
        run_len(0, n);
        check(16'(n), 16'h0006);
    endtask
    task automatic t_pre_wake();
        int n;
        wreg(`LMS_H_MASK, 16'h0002);
        wait_for(1, 1'b1);
        pulse(3);
        wait_for(0, 1'b1);
        pulse(0);
        tick(3);
        check({15'h0, seq_on}, 16'h0000);
        wait_for(2, 1'b1);
        run_len(0, n);
        check(16'(n), 16'h003C);
        expect_reg(`LMS_H_STATUS, 16'h0002);
        tick(1);
        check({15'h0, irq}, 16'h0000);
        stop();
    endtask
    // Preamble as long as sleep plus two windows, begun while idle
    task automatic t_long_pre();
        start(16'h0001 << `LMS_C_GO_PRE, 16'h0006, 16'h0003);
        @(posedge CLK);
        pre <= 1'b1;
        tick(20);
        check({15'h0, rx_on && !seq_on}, 16'h0001);
        @(posedge CLK);
        pre <= 1'b0;
        expect_reg(`LMS_H_STATUS, 16'h0002);
        stop();
    endtask
    task automatic t_sync_wake();
        int n;
        wreg(`LMS_H_MASK, 16'h0004);
        start(16'h0001 << `LMS_C_GO_SYNC, 16'h000C, 16'h0004);
        wait_for(0, 1'b1);
        run_len(0, n);
        check({15'h0, (n >= 3 && n <= 5)}, 16'h0001);
        wait_for(0, 1'b1);
        pulse(0);
        run_len(0, n);
        check({15'h0, (n >= 8 && n <= 11)}, 16'h0001);
        wait_for(0, 1'b1);
        pulse(0);
        pulse(1);
        wait_for(2, 1'b1);
        run_len(0, n);
        check(16'(n), 16'h003C);
        expect_reg(`LMS_H_STATUS, 16'h0006);
        stop();
    endtask
    task automatic t_crc_masked();
        pulse(2);
        tick(6);
        check({15'h0, irq}, 16'h0000);
        expect_reg(`LMS_H_STATUS, 16'h0001);
    endtask

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    initial begin
        {RST, wr, rd, pre, syn, crc, rssi, pay, fthr, fdr} = 10'h200;
        addr = 4'h0;
        wdata = 16'h0000;
        failures = 0;
        n_compared = 0;
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        tick(1);
        t_reset();
        t_no_signal();
        t_pre_wake();
        t_long_pre();
        t_sync_wake();
        t_crc_masked();
        close_out();
    end
endmodule
`default_nettype wire
